// ### dcadc_analog_model.sv
// Behavioural comparator and RC capacitor at the controller's far side
`timescale 1ns/100ps
`default_nettype none
module dcadc_analog_model #(
   parameter int FULL = 4096,
   parameter int SHIFT = 5
) (
   input wire logic clock_i,
   input wire logic charge_path_i,
   input wire logic discharge_path_i,
   input wire logic [12:0] vin_i,
   output logic sense_o
);
   int cap = 0;
   logic sense = 1'b0;
   // First-order RC; short tau so the first pass settles in sim
   always @(posedge clock_i) begin
      if (charge_path_i && !discharge_path_i) begin
         cap <= cap + ((FULL - cap) >>> SHIFT);
      end else begin
         cap <= cap - (cap >>> SHIFT);
      end
      sense <= (int'(vin_i) > cap);
   end
   assign sense_o = sense;
endmodule
`default_nettype wire

// ### dcadc_ctrl.sv
// Duty-cycle conversion controller top level
//
// Overview of operation
// - Sample comparator once per fixed counting step.
// - Sub counter counts charge steps; total counts all.
// - Clear both counters before first sample; total is loaded with 4096 - TOTAL_COUNT instead.
// - Total counter overflows after 2048 steps by default.
// - Input above capacitor drives reference select high.
// - Sub counter increments each charge step.
// - Capacitor above input drives low, sub idle.
// - Both decision paths take equal cycles.
// - Total overflow of the second pass ends conversion, presents counts.
// - Counters up to 12 bits, total selectable.
// - Window equals total count times step.
// - Two passes; first discarded, second gives result.
// - Input equals reference times sub over total.
`timescale 1ns/100ps
`default_nettype none
module dcadc_ctrl #(
   parameter int W = dcadc_pkg::CNT_W,
   parameter logic [11:0] TOTAL_COUNT = dcadc_pkg::TOTAL_DEFAULT
) (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic start_i,
   input wire logic comparator_sense_input_i,
   output logic charge_path_o,
   output logic discharge_path_o,
   output logic busy_o,
   output logic done_o,
   output logic [W-1:0] sub_count_o,
   output logic [W-1:0] total_count_o
);
   dcadc_pkg::dcadc_state_t state;
   dcadc_pkg::dcadc_state_t next_state;
   logic [W-1:0] sub_cnt;
   logic [W-1:0] next_sub_cnt;
   logic [W:0] tot_cnt;
   logic [W:0] next_tot_cnt;
   logic [1:0] pass;
   logic [1:0] next_pass;
   logic ref_high;
   logic next_ref_high;
   logic [W-1:0] res_sub;
   logic [W-1:0] next_res_sub;
   logic [W-1:0] res_tot;
   logic [W-1:0] next_res_tot;
   logic done;
   logic next_done;
   logic sample;
   logic run;
   logic [W:0] preload;
   logic overflow;
   // Four spare bits cover a full pass of counting cycles
   logic [W+3:0] win_cnt;
   logic [W+3:0] next_win_cnt;

   assign run = (state == dcadc_pkg::ST_RUN);

   dcadc_step_timer u_timer (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .run_i(run),
      .sample_o(sample)
   );

   // Preload so the carry out lands after TOTAL_COUNT steps
   assign preload = (W+1)'(1) << W;
   assign overflow = tot_cnt[W];

   always_comb begin
      next_state = state;
      next_sub_cnt = sub_cnt;
      next_tot_cnt = tot_cnt;
      next_pass = pass;
      next_ref_high = ref_high;
      next_res_sub = res_sub;
      next_res_tot = res_tot;
      next_done = done;
      unique case (state)
         dcadc_pkg::ST_IDLE, dcadc_pkg::ST_DONE: begin
            if (start_i) begin
               next_state = dcadc_pkg::ST_CLEAR;
               next_pass = 2'h0;
               next_done = 1'b0;
            end
         end
         dcadc_pkg::ST_CLEAR: begin
            next_sub_cnt = '0;
            next_tot_cnt = preload - {1'b0, W'(TOTAL_COUNT)};
            next_state = dcadc_pkg::ST_RUN;
         end
         dcadc_pkg::ST_RUN: begin
            if (overflow) begin
               if (pass + 2'h1 == dcadc_pkg::PASSES) begin
                  next_res_sub = sub_cnt;
                  next_res_tot = W'(TOTAL_COUNT);
                  next_done = 1'b1;
                  next_state = dcadc_pkg::ST_DONE;
               end else begin
                  // Capacitor stays near input across passes
                  next_pass = pass + 2'h1;
                  next_state = dcadc_pkg::ST_CLEAR;
               end
            end else if (sample) begin
               next_ref_high = comparator_sense_input_i;
               if (comparator_sense_input_i) begin
                  next_sub_cnt = sub_cnt + W'(1);
               end
               next_tot_cnt = tot_cnt + (W+1)'(1);
            end
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= dcadc_pkg::ST_IDLE;
         sub_cnt <= W'(dcadc_pkg::CNT_RESET);
         tot_cnt <= '0;
         pass <= 2'h0;
         ref_high <= 1'b0;
         res_sub <= W'(dcadc_pkg::CNT_RESET);
         res_tot <= W'(dcadc_pkg::CNT_RESET);
         done <= 1'b0;
      end else begin
         state <= next_state;
         sub_cnt <= next_sub_cnt;
         tot_cnt <= next_tot_cnt;
         pass <= next_pass;
         ref_high <= next_ref_high;
         res_sub <= next_res_sub;
         res_tot <= next_res_tot;
         done <= next_done;
      end
   end

   assign charge_path_o = ref_high;
   assign discharge_path_o = !ref_high;
   // Busy covers the clear cycles too
   assign busy_o = (state != dcadc_pkg::ST_IDLE) && (state != dcadc_pkg::ST_DONE);
   assign done_o = done;
   assign sub_count_o = res_sub;
   assign total_count_o = res_tot;

   // Cycles spent counting in one pass; feeds the window check only
   always_comb begin
      next_win_cnt = win_cnt;
      if (state == dcadc_pkg::ST_CLEAR) begin
         next_win_cnt = '0;
      end else if (run && !overflow) begin
         next_win_cnt = win_cnt + (W+4)'(1);
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         win_cnt <= '0;
      end else begin
         win_cnt <= next_win_cnt;
      end
   end

   chk_clear_before_run: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      state == dcadc_pkg::ST_CLEAR |=> sub_cnt == '0)
      else $error("sub counter not cleared");

   chk_sub_only_high: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      run && sample && !overflow && !comparator_sense_input_i |=> $stable(sub_cnt))
      else $error("sub counter moved on discharge step");

   chk_sub_inc_high: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      run && sample && !overflow && comparator_sense_input_i
      |=> sub_cnt == $past(sub_cnt) + W'(1))
      else $error("sub counter missed charge step");

   chk_ref_follows: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      run && sample && !overflow |=> charge_path_o == $past(comparator_sense_input_i))
      else $error("reference select wrong");

   chk_total_step: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      run && sample && !overflow |=> tot_cnt == $past(tot_cnt) + (W+1)'(1))
      else $error("total counter missed step");

   chk_overflow_ends: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      run && overflow |=> !run)
      else $error("pass ran past overflow");

   // Pass length in cycles, so a wrong preload or step length shows up
   chk_window_len: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      run && overflow
      |-> win_cnt == (W+4)'(TOTAL_COUNT) * (W+4)'(dcadc_pkg::STEP_CYCLES))
      else $error("conversion window length wrong");

   sequence s_sample;
      sample;
   endsequence
   // Twelve quiet cycles, then the next sample
   sequence s_gap;
      !sample [*7] ##1 !sample [*5] ##1 sample;
   endsequence

   chk_step_even: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      s_sample ##1 run |-> s_gap or (##[0:11] !run))
      else $error("uneven step length");

   chk_start_taken: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      !busy_o && start_i |=> busy_o && !done_o)
      else $error("start request not taken");

   chk_result_hold: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      done_o && !start_i |=> done_o && $stable(sub_count_o) && $stable(total_count_o))
      else $error("result not held");

   chk_done_total: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      $rose(done_o) |-> total_count_o == W'(TOTAL_COUNT) && sub_count_o <= total_count_o)
      else $error("result counts wrong");

   chk_two_pass: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      $rose(done_o) |-> pass == 2'h1)
      else $error("result before second pass");
endmodule
`default_nettype wire

// ### dcadc_ctrl_tb.sv
// Self-checking bench for the duty-cycle conversion controller
`timescale 1ns/100ps
`default_nettype none
module dcadc_ctrl_tb;
   localparam logic [11:0] TOTAL = 12'h0010;
   typedef struct {logic [12:0] vin; int lo; int hi;} dcadc_row_t;
   dcadc_row_t rows [5] = '{'{13'h0000, 0, 0}, '{13'h1000, 16, 16}, '{13'h0400, 2, 6},
      '{13'h0800, 6, 10}, '{13'h0c00, 10, 14}};
   logic clock, arst_n, start, sense, charge, discharge, busy, done;
   logic [11:0] sub, total, held;
   logic [12:0] vin;
   int num_errors, cmp_count, span_ref;
   dcadc_ctrl #(.TOTAL_COUNT(TOTAL)) u_dcadc_ctrl (.clock_i(clock), .arst_n_i(arst_n),
      .start_i(start), .comparator_sense_input_i(sense), .charge_path_o(charge),
      .discharge_path_o(discharge), .busy_o(busy), .done_o(done), .sub_count_o(sub),
      .total_count_o(total));
   dcadc_analog_model u_dcadc_analog_model (.clock_i(clock), .charge_path_i(charge),
      .discharge_path_i(discharge), .vin_i(vin), .sense_o(sense));
   always #5 clock = ~clock;
   task automatic check_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic check_cnt(input logic [11:0] got, input int lo, input int hi);
      cmp_count++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         num_errors++;
         $display("Error at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task automatic results;
      $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Extra start mid-run must be ignored and leave the span unchanged
   task automatic convert(input logic [12:0] level, input logic poke);
      int n;
      vin = level;
      @(negedge clock);
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      check_bit(busy, 1'b1);
      check_bit(done, 1'b0);
      n = 1;
      while (done !== 1'b1 && n < 1000) begin
         @(negedge clock);
         n++;
         start = (n == 100) && poke;
      end
      start = 1'b0;
      check_bit(n == 2 * (16 * 13 + 2) + 1, 1'b1);
      if (span_ref == 0) begin
         span_ref = n;
      end
      check_bit(n == span_ref, 1'b1);
      check_cnt(total, 16, 16);
      check_bit(busy, 1'b0);
      check_bit(charge, ~discharge);
      held = sub;
      repeat (20) @(negedge clock);
      check_bit(sub === held && done === 1'b1, 1'b1);
   endtask
   initial begin
      clock = 1'b0;
      arst_n = 1'b0;
      start = 1'b0;
      vin = 13'h0000;
      num_errors = 0;
      cmp_count = 0;
      span_ref = 0;
      repeat (16) @(negedge clock);
      check_bit(discharge & ~charge & ~done & ~busy, 1'b1);
      check_cnt(sub, 0, 0);
      arst_n = 1'b1;
      foreach (rows[i]) begin
         convert(rows[i].vin, 1'b0);
         check_cnt(sub, rows[i].lo, rows[i].hi);
      end
      convert(13'h1000, 1'b1);
      check_cnt(sub, 16, 16);
      check_bit(charge, 1'b1);
      vin = 13'h1000;
      @(negedge clock);
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      repeat (50) @(negedge clock);
      arst_n = 1'b0;
      @(negedge clock);
      check_bit(discharge & ~charge & ~done & ~busy, 1'b1);
      arst_n = 1'b1;
      convert(13'h0000, 1'b0);
      check_cnt(sub, 0, 0);
      check_bit(discharge, 1'b1);
      results;
   end
   initial begin
      #100000;
      num_errors++;
      results;
   end
endmodule
`default_nettype wire

// ### dcadc_pkg.sv
// Constants for the duty-cycle conversion controller
`default_nettype none
package dcadc_pkg;
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] TOTAL_DEFAULT = 12'h0800;
   localparam logic [CNT_W-1:0] CNT_RESET = 12'h0000;
   localparam int STEP_NS = 130;
   localparam int CLK_NS = 10;
   localparam int STEP_CYCLES = (STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);
   localparam logic [1:0] PASSES = 2'h2;
   typedef enum logic [1:0] {ST_IDLE, ST_CLEAR, ST_RUN, ST_DONE} dcadc_state_t;
endpackage
`default_nettype wire

// ### dcadc_step_timer.sv
// Fixed-length step timer, flags the sampling cycle of each step
`timescale 1ns/100ps
`default_nettype none
module dcadc_step_timer #(
   parameter logic [7:0] LAST = dcadc_pkg::STEP_LAST
) (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic run_i,
   output logic sample_o
);
   logic [7:0] count;
   logic [7:0] next_count;

   always_comb begin
      next_count = 8'h00;
      if (run_i && count != LAST) begin
         next_count = count + 8'h01;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count <= 8'h00;
      end else begin
         count <= next_count;
      end
   end

   // Same period whichever decision is taken
   assign sample_o = run_i && (count == LAST);
endmodule
`default_nettype wire
